// ===== logic/ufc_pkg.sv
// constants for the uart fifo control and dma ready block
package ufc_pkg;
    localparam int          UFC_DATA_W      = 8;
    localparam int          UFC_ADDR_W      = 3;
    localparam int          UFC_DEPTH       = 16;
    localparam int          UFC_PTR_W       = 4;
    localparam int          UFC_CNT_W       = 5;
    // register offsets
    localparam logic [2:0]  UFC_OFS_DATA    = 3'h0;
    localparam logic [2:0]  UFC_OFS_CTRL    = 3'h2;
    localparam logic [2:0]  UFC_OFS_STATUS  = 3'h5;
    localparam logic [2:0]  UFC_OFS_ALTFN   = 3'h7;
    // fifo_control_reg fields
    localparam int          UFC_FC_EN       = 0;
    localparam int          UFC_FC_RX_RST   = 1;
    localparam int          UFC_FC_TX_RST   = 2;
    localparam int          UFC_FC_DMA      = 3;
    localparam int          UFC_FC_TRIG_LO  = 6;
    localparam int          UFC_FC_TRIG_HI  = 7;
    // alternate_function_reg field: multi-function pin carries rx ready
    localparam int          UFC_AF_RX_DMA_REQUEST_N    = 0;
    // status register fields
    localparam int          UFC_ST_RX_AVAIL = 0;
    localparam int          UFC_ST_TX_EMPTY = 1;
    localparam int          UFC_ST_TX_FULL  = 2;
    localparam int          UFC_ST_RX_TRIG  = 3;
    // receive trigger encodings and thresholds
    localparam logic [1:0]  UFC_TRIG_SEL0   = 2'h0;
    localparam logic [1:0]  UFC_TRIG_SEL1   = 2'h1;
    localparam logic [1:0]  UFC_TRIG_SEL2   = 2'h2;
    localparam logic [4:0]  UFC_TRIG_LVL0   = 5'h01;
    localparam logic [4:0]  UFC_TRIG_LVL1   = 5'h04;
    localparam logic [4:0]  UFC_TRIG_LVL2   = 5'h08;
    localparam logic [4:0]  UFC_TRIG_LVL3   = 5'h0E;
    // capacity with fifos off (holding register only) and on
    localparam logic [4:0]  UFC_CAP_ONE     = 5'h01;
    localparam logic [4:0]  UFC_CAP_FULL    = 5'h10;
    localparam logic [4:0]  UFC_CNT_ZERO    = 5'h00;
    localparam logic [7:0]  UFC_BYTE_ZERO   = 8'h00;
endpackage

// ===== logic/ufc_fifo.sv
// sixteen entry byte fifo with flush and single-entry holding mode
`timescale 1ns/1ps
module ufc_fifo (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // control
    input  wire logic                        flush,
    input  wire logic                        limit_one,
    // write side
    input  wire logic                        push,
    input  wire logic [ufc_pkg::UFC_DATA_W-1:0] push_data,
    // read side
    input  wire logic                        pop,
    output logic      [ufc_pkg::UFC_DATA_W-1:0] head,
    output logic      [ufc_pkg::UFC_CNT_W-1:0]  count,
    output logic                             full,
    output logic                             empty
);
    import ufc_pkg::*;

    logic [UFC_DATA_W-1:0] mem [UFC_DEPTH];
    logic [UFC_PTR_W-1:0]  wr_ptr;
    logic [UFC_PTR_W-1:0]  rd_ptr;
    wire                   push_ok;
    wire                   pop_ok;

    // refuse writes when full and reads when empty
    assign full    = count >= (limit_one ? UFC_CAP_ONE : UFC_CAP_FULL);
    assign empty   = count == UFC_CNT_ZERO;
    assign push_ok = push && !full;
    assign pop_ok  = pop && !empty;
    assign head    = mem[rd_ptr];

    // storage, one flop row per entry
    for (genvar i = 0; i < UFC_DEPTH; i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (push_ok && wr_ptr == UFC_PTR_W'(i)) begin
                mem[i] <= push_data;
            end
        end
    end

    // pointers and count; flush only touches counters, never data or shifters
    always_ff @(posedge clk) begin
        if (reset || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= UFC_CNT_ZERO;
        end else begin
            wr_ptr <= wr_ptr + UFC_PTR_W'(push_ok);
            rd_ptr <= rd_ptr + UFC_PTR_W'(pop_ok);
            count  <= count + UFC_CNT_W'(push_ok) - UFC_CNT_W'(pop_ok);
        end
    end
endmodule

// ===== logic/ufc_channel.sv
// fifo control and dma ready signalling for one uart channel
// Operation
// - fifos on, dma mode 1: tx ready high only while tx fifo full
// - dma mode 1: tx ready low while any tx fifo location free
// - dma mode 1: rx ready low at trigger level or receive time-out
// - dma mode 1: rx ready stays low until rx fifo empty, then high
// - writing tx reset bit empties tx fifo, shifter untouched, bit self-clears
// - writing rx reset bit empties rx fifo, shifter untouched, bit self-clears
// - enable bit turns both fifos on; cleared disables both, reset default
// - other control bits ignored unless the same write sets enable
// - trigger field 00,01,10,11 selects 1, 4, 8, 14 characters
// - trigger in bits 7-6, dma mode bit 3, bits 5-4 read zero
// - mode 0 or fifos off: tx ready low when empty, high once loaded
// - mode 0: rx ready low while a character waits, high when none
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ufc_channel (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset,
    // register port
    input  wire logic [ufc_pkg::UFC_ADDR_W-1:0] addr,
    input  wire logic [ufc_pkg::UFC_DATA_W-1:0] wdata,
    input  wire logic                           wr,
    input  wire logic                           rd,
    output logic      [ufc_pkg::UFC_DATA_W-1:0] rdata,
    // transmit shifter side
    input  wire logic                           tx_shift_load,
    output logic      [ufc_pkg::UFC_DATA_W-1:0] tx_char,
    output logic                                tx_char_valid,
    // receive shifter side
    input  wire logic                           rx_char_push,
    input  wire logic [ufc_pkg::UFC_DATA_W-1:0] rx_char,
    input  wire logic                           rx_timeout,
    // dma ready pins
    output logic                                tx_dma_request_n,
    output logic                                multi_function_pin
);
    import ufc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    logic                 fifo_enable;
    logic                 dma_mode;
    logic [1:0]           rx_trig_sel;
    logic                 mf_rx_dma_request_n;
    logic                 rx_active;
    logic                 rx_dma_request_n;
    wire                  wr_data    = wr && addr == UFC_OFS_DATA;
    wire                  wr_ctrl    = wr && addr == UFC_OFS_CTRL;
    wire                  wr_altfn   = wr && addr == UFC_OFS_ALTFN;
    wire                  rd_data    = rd && addr == UFC_OFS_DATA;
    // a control write's bits other than enable count only with the enable bit set
    wire                  ctrl_take  = wr_ctrl && wdata[UFC_FC_EN];
    wire                  tx_flush   = ctrl_take && wdata[UFC_FC_TX_RST];
    wire                  rx_flush   = ctrl_take && wdata[UFC_FC_RX_RST];
    wire                  limit_one  = !fifo_enable;
    wire                  mode1      = fifo_enable && dma_mode;
    wire [UFC_DATA_W-1:0] tx_head;
    wire [UFC_DATA_W-1:0] rx_head;
    wire [UFC_CNT_W-1:0]  tx_count;
    wire [UFC_CNT_W-1:0]  rx_count;
    wire                  tx_full;
    wire                  tx_empty;
    wire                  rx_empty;
    logic [UFC_CNT_W-1:0] rx_trig_lvl;
    wire                  rx_trig_hit;

    ////////////////////////////////////////////////////////////////////////////
    // fifos; flush acts at the edge of the control write
    ufc_fifo u_tx_fifo (
        .clk       (clk),
        .reset     (reset),
        .flush     (tx_flush),
        .limit_one (limit_one),
        .push      (wr_data),
        .push_data (wdata),
        .pop       (tx_shift_load),
        .head      (tx_head),
        .count     (tx_count),
        .full      (tx_full),
        .empty     (tx_empty)
    );

    ufc_fifo u_rx_fifo (
        .clk       (clk),
        .reset     (reset),
        .flush     (rx_flush),
        .limit_one (limit_one),
        .push      (rx_char_push),
        .push_data (rx_char),
        .pop       (rd_data),
        .head      (rx_head),
        .count     (rx_count),
        .full      (),
        .empty     (rx_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // trigger threshold lookup
    always_comb begin
        case (rx_trig_sel)
            UFC_TRIG_SEL0: rx_trig_lvl = UFC_TRIG_LVL0;
            UFC_TRIG_SEL1: rx_trig_lvl = UFC_TRIG_LVL1;
            UFC_TRIG_SEL2: rx_trig_lvl = UFC_TRIG_LVL2;
            default:       rx_trig_lvl = UFC_TRIG_LVL3;
        endcase
    end
    assign rx_trig_hit = rx_count >= rx_trig_lvl;

    // next values of the ready outputs
    wire next_rx_active = (rx_trig_hit || rx_timeout) ? 1'b1
                        : rx_empty ? 1'b0 : rx_active;
    wire next_tx_n      = mode1 ? tx_full : !tx_empty;
    wire next_rx_n      = mode1 ? !next_rx_active : rx_empty;
    // pin shows rx ready only once routed there; idles high otherwise
    wire next_mf        = mf_rx_dma_request_n ? next_rx_n : 1'b1;

    // readback mux; reserved bits 5-4 and reset bits read zero
    wire [UFC_DATA_W-1:0] ctrl_view =
        {rx_trig_sel, 2'b00, dma_mode, 2'b00, fifo_enable};
    wire [UFC_DATA_W-1:0] status_view =
        {4'h0, rx_trig_hit, tx_full, tx_empty, !rx_empty};
    wire [UFC_DATA_W-1:0] next_rdata =
        !rd                      ? UFC_BYTE_ZERO :
        addr == UFC_OFS_DATA     ? rx_head :
        addr == UFC_OFS_CTRL     ? ctrl_view :
        addr == UFC_OFS_STATUS   ? status_view :
        addr == UFC_OFS_ALTFN    ? {7'h00, mf_rx_dma_request_n} : UFC_BYTE_ZERO;

    ////////////////////////////////////////////////////////////////////////////
    // control register; a write with enable clear only disables
    always_ff @(posedge clk) begin
        if (reset) begin
            fifo_enable <= 1'b0;
            dma_mode    <= 1'b0;
            rx_trig_sel <= UFC_TRIG_SEL0;
            mf_rx_dma_request_n    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                fifo_enable <= wdata[UFC_FC_EN];
            end
            if (ctrl_take) begin
                dma_mode    <= wdata[UFC_FC_DMA];
                rx_trig_sel <= wdata[UFC_FC_TRIG_HI:UFC_FC_TRIG_LO];
            end
            if (wr_altfn) begin
                mf_rx_dma_request_n <= wdata[UFC_AF_RX_DMA_REQUEST_N];
            end
        end
    end

    // registered outputs; everything leaves from a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_active          <= 1'b0;
            tx_dma_request_n   <= 1'b0;
            rx_dma_request_n   <= 1'b1;
            multi_function_pin <= 1'b1;
            rdata              <= UFC_BYTE_ZERO;
            tx_char            <= UFC_BYTE_ZERO;
            tx_char_valid      <= 1'b0;
        end else begin
            rx_active          <= next_rx_active && mode1;
            tx_dma_request_n   <= next_tx_n;
            rx_dma_request_n   <= next_rx_n;
            multi_function_pin <= next_mf;
            rdata              <= next_rdata;
            tx_char            <= tx_head;
            tx_char_valid      <= !tx_empty && !tx_shift_load;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_ctl_write_off;
        wr_ctrl && !wdata[UFC_FC_EN];
    endsequence
    sequence s_ctl_fields_held;
        $stable(dma_mode) && $stable(rx_trig_sel) && !fifo_enable;
    endsequence
    // ready low from a mode 1 decision, fifo still holding data
    sequence s_rx_ready_owed;
        $past(mode1) && mode1 && !rx_dma_request_n && !rx_empty ##1 mode1 && !rx_empty;
    endsequence

    chk_tx_full_high: assert property (mode1 && tx_full |=> tx_dma_request_n)
        else $error("tx ready not high on full fifo in mode 1");
    chk_tx_free_low: assert property (mode1 && !tx_full |=> !tx_dma_request_n)
        else $error("tx ready not low with free space in mode 1");
    chk_rx_trig_low: assert property (
        mode1 && (rx_trig_hit || rx_timeout) |=> !rx_dma_request_n)
        else $error("rx ready not low at trigger or time-out");
    chk_rx_hold_empty: assert property (s_rx_ready_owed |=> !rx_dma_request_n)
        else $error("rx ready released before fifo emptied");
    chk_tx_flush_done: assert property (tx_flush |=> tx_empty)
        else $error("tx fifo not empty one clock after reset bit");
    chk_rx_flush_done: assert property (rx_flush && !rx_char_push |=> rx_empty)
        else $error("rx fifo not empty one clock after reset bit");
    chk_enable_write: assert property (
        wr_ctrl |=> fifo_enable == $past(wdata[UFC_FC_EN]))
        else $error("fifo enable does not follow control write");
    chk_ignore_fields: assert property (s_ctl_write_off |=> s_ctl_fields_held)
        else $error("control fields changed on write with enable clear");
    chk_tx_mode0_empty: assert property (
        !mode1 && tx_empty |=> !tx_dma_request_n ##0 $past(tx_empty))
        else $error("tx ready not low on empty transmitter in mode 0");
    chk_rx_mode0_avail: assert property (
        !mode1 |=> rx_dma_request_n == $past(rx_empty))
        else $error("rx ready does not track data in mode 0");
endmodule

// ===== verif/ufc_far_model.sv
// far-side model: receive shifter, time-out source and transmit shifter
`timescale 1ns/1ps
module ufc_far_model (
    // clock
    input  wire logic                           clk,
    // transmit shifter side
    input  wire logic                           tx_char_valid,
    output logic                                tx_shift_load,
    // receive shifter side
    output logic                                rx_char_push,
    output logic [ufc_pkg::UFC_DATA_W-1:0]      rx_char,
    output logic                                rx_timeout
);
    import ufc_pkg::*;
    initial begin
        tx_shift_load = 1'b0;
        rx_char_push  = 1'b0;
        rx_char       = 8'hA5;
        rx_timeout    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one byte per pulse; the data line shows the inverse once released
    task automatic push_rx(input logic [7:0] b);
        @(posedge clk);
        rx_char_push <= 1'b1;
        rx_char      <= b;
        @(posedge clk);
        rx_char_push <= 1'b0;
        rx_char      <= ~b;
    endtask
    // receive time-out event, one cycle
    task automatic pulse_timeout();
        @(posedge clk);
        rx_timeout <= 1'b1;
        @(posedge clk);
        rx_timeout <= 1'b0;
    endtask
    // shifter takes a byte; never two loads back to back since tx_char lags
    task automatic load_tx();
        // look a step after the edge so the flop has settled
        for (int k = 0; k < 50 && tx_char_valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        tx_shift_load <= 1'b1;
        @(posedge clk);
        tx_shift_load <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// ===== verif/tb_uart_fifo_control_dma_ready.sv
// self-checking bench for the fifo control and dma ready channel
`timescale 1ns/1ps
module tb_uart_fifo_control_dma_ready;
    import ufc_pkg::*;
    typedef struct {logic [7:0] ctrl; int n; logic pin; logic [7:0] view;} ufc_row_t;
    logic       clk, reset, wr, rd, tx_shift_load, tx_char_valid;
    logic       rx_char_push, rx_timeout, tx_dma_request_n, multi_function_pin;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, tx_char, rx_char;
    int         mismatches, checks_done;
    ufc_row_t   rows [10];
    ufc_channel dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .tx_shift_load(tx_shift_load), .tx_char(tx_char),
        .tx_char_valid(tx_char_valid), .rx_char_push(rx_char_push), .rx_char(rx_char),
        .rx_timeout(rx_timeout), .tx_dma_request_n(tx_dma_request_n),
        .multi_function_pin(multi_function_pin));
    ufc_far_model u_far (.clk(clk), .tx_char_valid(tx_char_valid),
        .tx_shift_load(tx_shift_load), .rx_char_push(rx_char_push), .rx_char(rx_char),
        .rx_timeout(rx_timeout));
    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // comparison, counted
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobe; an idle edge separates transfers
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read strobe, data checked in the following cycle only
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    // ready outputs lag the fifo state by a register
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pins(input logic tx_exp, input logic mf_exp);
        chk("tx ready", {7'h00, tx_exp}, {7'h00, tx_dma_request_n});
        chk("rx ready pin", {7'h00, mf_exp}, {7'h00, multi_function_pin});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        clk = 0; reset = 1; wr = 0; rd = 0; addr = '0; wdata = '0;
        mismatches = 0; checks_done = 0;
        // every row also flushes rx; all but the two 03 rows set the unused bits 5-4
        rows = '{'{8'h3B,0,1'b1,8'h09}, '{8'h3B,1,1'b0,8'h09}, '{8'h7B,3,1'b1,8'h49},
            '{8'h7B,4,1'b0,8'h49}, '{8'hBB,7,1'b1,8'h89}, '{8'hBB,8,1'b0,8'h89},
            '{8'hFB,13,1'b1,8'hC9}, '{8'hFB,14,1'b0,8'hC9}, '{8'h03,0,1'b1,8'h01},
            '{8'h03,1,1'b0,8'h01}};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        wr_reg(UFC_OFS_ALTFN, 8'h01);
        for (int i = 0; i < 10; i++) begin
            wr_reg(UFC_OFS_CTRL, rows[i].ctrl);
            for (int k = 0; k < rows[i].n; k++) u_far.push_rx(8'(k));
            settle();
            chk("rx ready pin", {7'h00, rows[i].pin}, {7'h00, multi_function_pin});
            rd_reg(UFC_OFS_CTRL, rows[i].view, "ctrl view");
        end
        $display("test rows done");
        // second reset mid-run
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        settle();
        pins(1'b0, 1'b1);
        rd_reg(UFC_OFS_CTRL, 8'h00, "ctrl after reset");
        // data waiting but pin not yet routed: pin idles high
        u_far.push_rx(8'h11);
        settle();
        pins(1'b0, 1'b1);
        $display("test reset done");
        // rx ready holds below trigger until empty
        wr_reg(UFC_OFS_ALTFN, 8'h01);
        rd_reg(UFC_OFS_ALTFN, 8'h01, "alt function");
        pins(1'b0, 1'b0);
        wr_reg(UFC_OFS_CTRL, 8'h4B);
        for (int k = 0; k < 4; k++) u_far.push_rx(8'hA0 + 8'(k));
        settle();
        pins(1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            rd_reg(UFC_OFS_DATA, 8'hA0 + 8'(k), "rx data");
            settle();
            pins(1'b0, k == 3);
        end
        // time-out below trigger
        wr_reg(UFC_OFS_CTRL, 8'hCB);
        u_far.push_rx(8'h55);
        settle();
        pins(1'b0, 1'b1);
        u_far.pulse_timeout();
        settle();
        pins(1'b0, 1'b0);
        rd_reg(UFC_OFS_DATA, 8'h55, "rx data");
        settle();
        pins(1'b0, 1'b1);
        $display("test rx hold done");
        // tx fill to full, then one load frees a place
        wr_reg(UFC_OFS_CTRL, 8'h0D);
        for (int k = 0; k < 16; k++) begin
            wr_reg(UFC_OFS_DATA, 8'(k));
            settle();
            pins(k == 15, 1'b1);
        end
        u_far.load_tx();
        settle();
        pins(1'b0, 1'b1);
        // flush then data write on the very next edge lands in the emptied fifo
        @(posedge clk);
        wr <= 1'b1; addr <= UFC_OFS_CTRL; wdata <= 8'h0D;
        @(posedge clk);
        addr <= UFC_OFS_DATA; wdata <= 8'h5A;
        @(posedge clk);
        wr <= 1'b0;
        settle();
        chk("tx char", 8'h5A, tx_char);
        rd_reg(UFC_OFS_STATUS, 8'h00, "status");
        chk("tx valid", 8'h01, {7'h00, tx_char_valid});
        $display("test tx done");
        // enable cleared: other bits ignored, holding register only
        wr_reg(UFC_OFS_CTRL, 8'hC0);
        rd_reg(UFC_OFS_CTRL, 8'h08, "ctrl view");
        settle();
        pins(1'b1, 1'b1);
        u_far.load_tx();
        settle();
        pins(1'b0, 1'b1);
        chk("tx valid", 8'h00, {7'h00, tx_char_valid});
        wr_reg(UFC_OFS_DATA, 8'h77);
        wr_reg(UFC_OFS_DATA, 8'h78);
        settle();
        pins(1'b1, 1'b1);
        rd_reg(UFC_OFS_STATUS, 8'h04, "status");
        // unmapped places read zero and ignore writes
        wr_reg(3'h3, 8'hFF);
        rd_reg(3'h1, 8'h00, "unmapped");
        rd_reg(UFC_OFS_CTRL, 8'h08, "ctrl view");
        $display("test disabled done");
        complete_run();
    end
endmodule
